// ### output_macrocells_cfg.svh
/*
 * Constants for the ten-cell programmable output macrocell block:
 * array geometry, term layout, configuration codes, reset values and
 * standby timing.
 * Assumes it is included by its bare name; holds definitions only.
 */
`ifndef OUTPUT_MACROCELLS_CFG_SVH
`define OUTPUT_MACROCELLS_CFG_SVH

// -----------------------------------------------------------------
// array geometry
// -----------------------------------------------------------------
`define NUM_CELLS 10
`define NUM_DED_INPUTS 11
`define NUM_SIGS 22
`define NUM_COLS 44
`define NUM_TERMS 132
`define MIN_LOGIC_TERMS 8
`define MAX_LOGIC_TERMS 16
`define CLR_TERM_IDX 0
`define SET_TERM_IDX 131

// -----------------------------------------------------------------
// pin vector layout after the input filter
// -----------------------------------------------------------------
`define PIN_W 23
`define PIN_CLK_BIT 0
`define PIN_PD_BIT 22

// -----------------------------------------------------------------
// output-enable configuration codes, two bits per cell
// -----------------------------------------------------------------
`define OE_CFG_TERM 2'h0
`define OE_CFG_ON 2'h1
`define OE_CFG_OFF 2'h2

// -----------------------------------------------------------------
// register values
// -----------------------------------------------------------------
`define CLEAR_VALUE 10'h000
`define SET_VALUE 10'h3FF

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define MCLK_NS 8
`define IDLE_NS 100
`define IDLE_CYC ((`IDLE_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// ### output_macrocells_pkg.sv
/*
 * Types shared by the macrocell block.
 * Assumes the constants header is compiled alongside.
 */
package output_macrocells_pkg;

   // power state of the whole device
   typedef enum logic {
      PWR_ACTIVE,
      PWR_STANDBY
   } pwr_state_t;

   // fuse row of one product term: true and complement column per signal
   typedef logic [43:0] term_row_t;

endpackage : output_macrocells_pkg

// ### output_macrocells.sv
/*
 * Ten programmable output macrocells fed by a shared AND array,
 * with shared clear and set terms, preload and standby control.
 * Assumes pins arrive asynchronous to mclk and are filtered here;
 * the fuse map and cell configuration are static while running.
 */
//
// Contract
// (RQ1) ten cells, pairs of 8 to 16 terms
// (RQ2) extra term per cell drives output enable
// (RQ3) per-cell output polarity, true or inverted
// (RQ4) clear term forces registers zero at once
// (RQ5) set term loads ones at next clock
// (RQ6) clear and set act on flip-flop state
// (RQ7) two bits per cell select mode, polarity
// (RQ8) registered pin driven from flip-flop through polarity
// (RQ9) registered feedback is inverted flip-flop output
// (RQ10) registered pin is output only
// (RQ11) combinatorial pin driven by sum term
// (RQ12) combinatorial enable on, off or term
// (RQ13) combinatorial feedback taken from pin level
// (RQ14) registers reset at power-up, preload available
// (RQ15) standby by inactivity or power-down pin
// (RQ16) preload forces any state synchronously
// (RQ17) common rising clock, clear beats set
`timescale 1ns/1ps
`include "output_macrocells_cfg.svh"

module output_macrocells #(
   parameter bit STANDBY_BY_PIN = 1'b0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [`NUM_TERMS*`NUM_COLS-1:0] fuse_map,
   input wire logic [`NUM_CELLS-1:0] mode_select_bit_high,
   input wire logic [`NUM_CELLS-1:0] polarity_true,
   input wire logic [2*`NUM_CELLS-1:0] comb_oe_cfg,
   input wire logic preload_en,
   input wire logic [`NUM_CELLS-1:0] preload_value,
   input wire logic clock_pin,
   input wire logic [`NUM_DED_INPUTS-1:0] input_pins,
   input wire logic [`NUM_CELLS-1:0] io_in,
   input wire logic power_down_pin,
   output logic [`NUM_CELLS-1:0] io_out,
   output logic [`NUM_CELLS-1:0] io_oe_n,
   output logic [`NUM_CELLS-1:0] reg_state,
   output logic standby
);

   // -----------------------------------------------------------------
   // term layout helpers
   // -----------------------------------------------------------------

   // logic terms of a cell: 8,10,12,14,16,16,14,12,10,8
   function automatic int cell_terms(input int c);
      int k;
      k = (c < 5) ? c : (9 - c);
      return `MIN_LOGIC_TERMS + 2 * k;
   endfunction : cell_terms

   // index of a cell's enable term; its logic terms follow it
   function automatic int cell_base(input int c);
      int b;
      b = `CLR_TERM_IDX + 1;
      for (int i = 0; i < c; i++) begin
         b = b + 1 + cell_terms(i);
      end
      return b;
   endfunction : cell_base

   // a term is the and of its connected literals; no literal means false
   function automatic logic term_eval(
      input output_macrocells_pkg::term_row_t mask,
      input output_macrocells_pkg::term_row_t lit
   );
      return (|mask) & (&(~mask | lit));
   endfunction : term_eval

   // -----------------------------------------------------------------
   // pin input filter
   // -----------------------------------------------------------------
   logic [`PIN_W-1:0] pin_raw;
   logic [`PIN_W-1:0] pin_s1_r;
   logic [`PIN_W-1:0] pin_s2_r;
   logic [`PIN_W-1:0] pin_s3_r;
   logic [`PIN_W-1:0] pin_f_r;
   logic [`PIN_W-1:0] pin_f_nxt;
   logic [`PIN_W-1:0] pin_prev_r;

   assign pin_raw = {power_down_pin, io_in, input_pins, clock_pin};

   // a level counts only once the second and third stage agree
   assign pin_f_nxt = (pin_s2_r & ~(pin_s2_r ^ pin_s3_r))
                    | (pin_f_r & (pin_s2_r ^ pin_s3_r));

   // three-stage synchroniser and agreed level
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
         pin_f_r <= '0;
         pin_prev_r <= '0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_f_r <= pin_f_nxt;
         pin_prev_r <= pin_f_r;
      end
   end

   logic [`PIN_W-1:0] pin_chg;
   logic activity;
   logic clk_rise;
   logic pd_level;
   logic [`NUM_CELLS-1:0] io_f;

   assign pin_chg = pin_f_r ^ pin_prev_r;
   assign activity = |pin_chg[`PIN_PD_BIT-1:0];
   assign clk_rise = pin_chg[`PIN_CLK_BIT] & pin_f_r[`PIN_CLK_BIT]; // RQ17
   assign pd_level = pin_f_r[`PIN_PD_BIT];
   assign io_f = pin_f_r[`PIN_PD_BIT-1 -: `NUM_CELLS];

   // -----------------------------------------------------------------
   // standby control
   // -----------------------------------------------------------------
   output_macrocells_pkg::pwr_state_t pwr_r;
   logic [7:0] idle_cnt_r;
   logic run;

   // the waking transition is itself processed, so no edge is lost
   always_comb begin
      if (STANDBY_BY_PIN) begin
         run = ~pd_level; // RQ15
      end else begin
         run = (pwr_r == output_macrocells_pkg::PWR_ACTIVE) | activity;
      end
   end

   // inactivity timer or power-down pin moves between active and standby
   always_ff @(posedge mclk) begin
      if (rst) begin
         pwr_r <= output_macrocells_pkg::PWR_ACTIVE;
         idle_cnt_r <= 8'h00;
      end else begin
         unique case (pwr_r)
            output_macrocells_pkg::PWR_ACTIVE: begin
               if (STANDBY_BY_PIN) begin
                  if (pd_level) begin
                     pwr_r <= output_macrocells_pkg::PWR_STANDBY; // RQ15
                  end
                  idle_cnt_r <= 8'h00;
               end else if (activity) begin
                  idle_cnt_r <= 8'h00;
               end else if (idle_cnt_r == 8'(`IDLE_CYC - 1)) begin
                  pwr_r <= output_macrocells_pkg::PWR_STANDBY; // RQ15
                  idle_cnt_r <= 8'h00;
               end else begin
                  idle_cnt_r <= idle_cnt_r + 8'h01;
               end
            end
            output_macrocells_pkg::PWR_STANDBY: begin
               idle_cnt_r <= 8'h00;
               if (STANDBY_BY_PIN ? ~pd_level : activity) begin
                  pwr_r <= output_macrocells_pkg::PWR_ACTIVE; // RQ15
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // feedback and AND array
   // -----------------------------------------------------------------
   logic [`NUM_CELLS-1:0] q_r;
   logic [`NUM_CELLS-1:0] out_r;
   logic [`NUM_CELLS-1:0] oe_n_r;
   logic [`NUM_CELLS-1:0] fb;
   logic [`NUM_SIGS-1:0] sig;
   output_macrocells_pkg::term_row_t lit;
   logic [`NUM_TERMS-1:0] pt;

   // registered cells feed back the inverted flip-flop; others the pin
   always_comb begin
      for (int c = 0; c < `NUM_CELLS; c++) begin
         if (mode_select_bit_high[c]) begin
            fb[c] = oe_n_r[c] ? io_f[c] : out_r[c]; // RQ13
         end else begin
            fb[c] = ~q_r[c]; // RQ9 RQ10
         end
      end
   end

   assign sig = {fb, pin_f_r[`NUM_DED_INPUTS:0]};

   // each signal gives a true and a complement column
   always_comb begin
      for (int i = 0; i < `NUM_SIGS; i++) begin
         lit[2*i] = sig[i];
         lit[2*i+1] = ~sig[i];
      end
   end

   // every product term of the array
   always_comb begin
      for (int t = 0; t < `NUM_TERMS; t++) begin
         pt[t] = term_eval(fuse_map[t*`NUM_COLS +: `NUM_COLS], lit);
      end
   end

   // -----------------------------------------------------------------
   // sum terms and enable terms per cell
   // -----------------------------------------------------------------
   logic [`NUM_CELLS-1:0] sum;
   logic [`NUM_CELLS-1:0] oe_term;
   logic clr_term;
   logic set_term;

   // or of each cell's own logic terms, 8 to 16 of them
   always_comb begin
      for (int c = 0; c < `NUM_CELLS; c++) begin
         sum[c] = 1'b0;
         oe_term[c] = pt[cell_base(c)]; // RQ2
         for (int k = 0; k < `MAX_LOGIC_TERMS; k++) begin
            if (k < cell_terms(c)) begin
               sum[c] = sum[c] | pt[cell_base(c) + 1 + k]; // RQ1
            end
         end
      end
   end

   assign clr_term = pt[`CLR_TERM_IDX];
   assign set_term = pt[`SET_TERM_IDX];

   // -----------------------------------------------------------------
   // macrocell flip-flops
   // -----------------------------------------------------------------

   // clear at once, else preload, else set or sum on the clock edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         q_r <= `CLEAR_VALUE; // RQ14
      end else if (run) begin
         if (clr_term) begin
            q_r <= `CLEAR_VALUE; // RQ4 RQ6 RQ17
         end else if (preload_en) begin
            q_r <= preload_value; // RQ14 RQ16
         end else if (clk_rise) begin
            if (set_term) begin
               q_r <= `SET_VALUE; // RQ5 RQ6
            end else begin
               q_r <= sum; // RQ17
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // output select, polarity and enable
   // -----------------------------------------------------------------
   logic [`NUM_CELLS-1:0] out_nxt;
   logic [`NUM_CELLS-1:0] oe_nxt;
   logic [1:0] oe_code;

   // mode bit picks source and enable; polarity bit inverts the pin
   always_comb begin
      oe_code = 2'h0;
      for (int c = 0; c < `NUM_CELLS; c++) begin
         oe_code = comb_oe_cfg[2*c +: 2];
         if (mode_select_bit_high[c]) begin
            out_nxt[c] = sum[c] ^ ~polarity_true[c]; // RQ3 RQ7 RQ11
            if (oe_code == `OE_CFG_ON) begin
               oe_nxt[c] = 1'b1; // RQ12
            end else if (oe_code == `OE_CFG_OFF) begin
               oe_nxt[c] = 1'b0; // RQ12
            end else begin
               oe_nxt[c] = oe_term[c]; // RQ12
            end
         end else begin
            out_nxt[c] = q_r[c] ^ ~polarity_true[c]; // RQ3 RQ7 RQ8
            oe_nxt[c] = oe_term[c]; // RQ2
         end
      end
   end

   // pin drivers hold their last value through standby
   always_ff @(posedge mclk) begin
      if (rst) begin
         out_r <= '0;
         oe_n_r <= '1;
      end else if (run) begin
         out_r <= out_nxt;
         oe_n_r <= ~oe_nxt;
      end
   end

   // status outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_state <= `CLEAR_VALUE;
         standby <= 1'b0;
      end else begin
         reg_state <= q_r;
         standby <= (pwr_r == output_macrocells_pkg::PWR_STANDBY) & ~run;
      end
   end

   assign io_out = out_r;
   assign io_oe_n = oe_n_r;

endmodule : output_macrocells

// ### output_macrocells_properties.sv
/* Port checker of the macrocell block, bound to its top module.
   Assumes the clear term is held off while preload is in use. */
`timescale 1ns/1ps
`include "output_macrocells_cfg.svh"
module output_macrocells_properties #(
   parameter bit STANDBY_BY_PIN = 1'h0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [9:0] mode_select_bit_high,
   input wire logic [9:0] polarity_true,
   input wire logic [19:0] comb_oe_cfg,
   input wire logic preload_en,
   input wire logic [9:0] preload_value,
   input wire logic clock_pin,
   input wire logic [10:0] input_pins,
   input wire logic [9:0] io_in,
   input wire logic [9:0] io_out,
   input wire logic [9:0] io_oe_n,
   input wire logic [9:0] reg_state,
   input wire logic standby
);
   logic [4:0] quiet_r;
   wire logic [9:0] regd = ~mode_select_bit_high;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // counts cycles without any pin activity
   always_ff @(posedge mclk) begin
      if (rst || $changed({clock_pin, input_pins, io_in}))
         quiet_r <= 5'h00;
      else if (quiet_r != 5'h1F)
         quiet_r <= quiet_r + 5'h01;
   end
   a_reset_idle: assert property (
      disable iff (1'h0) rst |=> io_oe_n == 10'h3FF
      && reg_state == 10'h000 && !standby) else $error("bad reset state");
   a_pin_polarity: assert property (
      !$past(rst) && !$past(rst, 2)
      |-> ((io_out ^ reg_state ^ ~polarity_true) & regd) == 10'h000)
      else $error("registered pin not flip-flop through polarity");
   a_preload_load: assert property (
      (preload_en && !standby)[*3]
      |-> (reg_state & regd) == ($past(preload_value, 2) & regd))
      else $error("preload value not loaded");
   a_idle_sleep: assert property (
      !STANDBY_BY_PIN && quiet_r >= 5'h18 |-> standby)
      else $error("no standby after idle inputs");
   a_wake_up: assert property (
      standby && $changed(input_pins) |-> ##[1:8] !standby)
      else $error("no wake on input change");
   a_frozen_state: assert property (
      standby && $past(standby) && $past(standby, 2) |-> $stable(reg_state))
      else $error("state moved in standby");
   // per-cell enable settings of combinatorial cells
   for (genvar c = 0; c < 10; c++) begin : g_cell
      wire logic [1:0] cfg = comb_oe_cfg[2*c+:2];
      a_oe_on: assert property (
         mode_select_bit_high[c] && cfg == `OE_CFG_ON && $stable(cfg)
         && !standby && !$past(rst) |-> !io_oe_n[c])
         else $error("enable on not driving");
      a_oe_off: assert property (
         mode_select_bit_high[c] && cfg == `OE_CFG_OFF && $stable(cfg)
         && !standby && !$past(rst) |-> io_oe_n[c])
         else $error("enable off still driving");
   end
   c_sleep: cover property (standby);
   c_wake: cover property ($fell(standby));
   c_preload: cover property (preload_en[*3]);
endmodule : output_macrocells_properties

bind output_macrocells output_macrocells_properties #(
   .STANDBY_BY_PIN(STANDBY_BY_PIN)
) i_output_macrocells_properties (.mclk, .rst, .mode_select_bit_high,
   .polarity_true, .comb_oe_cfg, .preload_en, .preload_value, .clock_pin,
   .input_pins, .io_in, .io_out, .io_oe_n, .reg_state, .standby);

// ### board_model.sv
/* Board model closing the ten I/O pins.
   Assumes the board drives every pin that the device releases. */
`timescale 1ns/1ps
module board_model (
   input wire logic [9:0] io_out,
   input wire logic [9:0] io_oe_n,
   input wire logic [9:0] board_drv,
   output logic [9:0] io_in
);
   // pin level: device where enabled, board elsewhere
   assign io_in = (io_out & ~io_oe_n) | (board_drv & io_oe_n);
endmodule : board_model

// ### tb.sv
/* Self-checking bench of the macrocell block.
   Assumes the board model closes the I/O pins. */
`timescale 1ns/1ps
`include "output_macrocells_cfg.svh"
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin \
   mismatches++; $display("[ERR] %s exp %h got %h", n, e, v); end end
module tb;
   logic mclk = 0, rst = 1, clock_pin = 0, preload_en = 0;
   logic [`NUM_TERMS*`NUM_COLS-1:0] fuse_map = '0;
   logic [19:0] comb_oe_cfg = 20'h00004;
   logic [9:0] preload_value = 10'h000, board_drv = 10'h155;
   logic [10:0] input_pins = 11'h000;
   logic [9:0] io_in, io_out, io_oe_n, reg_state;
   logic standby;
   int mismatches = 0, comparisons = 0;
   output_macrocells i_output_macrocells (.mclk, .rst, .fuse_map,
      .mode_select_bit_high(10'h002), .polarity_true(10'h3FE),
      .comb_oe_cfg, .preload_en, .preload_value, .clock_pin,
      .input_pins, .io_in, .power_down_pin(1'h0), .io_out, .io_oe_n,
      .reg_state, .standby);
   board_model i_board_model (.io_out, .io_oe_n, .board_drv, .io_in);
   // free-running system clock
   initial forever #4 mclk = ~mclk;
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : w
   // one pin clock pulse, then time to settle
   task automatic pulse();
      clock_pin = 1;
      w(3);
      clock_pin = 0;
      w(8);
   endtask : pulse
   task automatic t_reg();
      input_pins = 11'h003;
      pulse();
      `CHK("q0", 1'h1, reg_state[0])
      `CHK("pin0", 1'h0, io_out[0])
      `CHK("oe0", 1'h0, io_oe_n[0])
      `CHK("fb2", 1'h1, reg_state[2])
   endtask : t_reg
   task automatic t_set_clear();
      input_pins = 11'h200;
      pulse();
      `CHK("set", 10'h3FD, reg_state & 10'h3FD)
      input_pins = 11'h600;
      w(8);
      `CHK("clr", 10'h000, reg_state & 10'h3FD)
      `CHK("clr_pin", 1'h1, io_out[0])
      pulse();
      `CHK("clr_set", 10'h000, reg_state & 10'h3FD)
      input_pins = 11'h000;
   endtask : t_set_clear
   task automatic t_preload();
      // clear outranks preload: let the filtered clear term fall first
      w(8);
      preload_value = 10'h2A5;
      preload_en = 1;
      w(4);
      `CHK("preload", 10'h2A5, reg_state & 10'h3FD)
      preload_en = 0;
   endtask : t_preload
   task automatic t_comb();
      input_pins = 11'h001;
      w(8);
      `CHK("comb", 1'h1, io_out[1])
      `CHK("oe_on", 1'h0, io_oe_n[1])
      comb_oe_cfg = 20'h00008;
      w(3);
      `CHK("oe_off", 1'h1, io_oe_n[1])
      comb_oe_cfg = 20'h00000;
      w(3);
      `CHK("oe_term0", 1'h1, io_oe_n[1])
      input_pins = 11'h003;
      w(8);
      `CHK("oe_term1", 1'h0, io_oe_n[1])
   endtask : t_comb
   task automatic t_sleep();
      w(24);
      `CHK("sleep", 1'h1, standby)
      input_pins = 11'h000;
      w(8);
      `CHK("wake", 1'h0, standby)
   endtask : t_sleep
   task automatic summarize();
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // guard against a hung run
   initial begin
      #100000;
      mismatches++;
      summarize();
   end
   // fuse map, reset, then the scenarios
   initial begin
      fuse_map[22] = 1'h1;
      fuse_map[5784] = 1'h1;
      fuse_map[48] = 1'h1;
      fuse_map[90] = 1'h1;
      fuse_map[444] = 1'h1;
      fuse_map[486] = 1'h1;
      // cell 2 logic term reads its own inverted flip-flop feedback
      fuse_map[996] = 1'h1;
      w(2);
      rst = 0;
      `CHK("oe_n", 10'h3FF, io_oe_n)
      `CHK("state", 10'h000, reg_state)
      t_reg();
      t_set_clear();
      t_preload();
      t_comb();
      t_sleep();
      summarize();
   end
endmodule : tb
